// ### logic/mseq_pkg.sv
// constants and types shared by the microprogram sequencer
package mseq_pkg;
    // widths
    localparam int ADDR_W = 14;
    localparam int MI_W = 17;
    localparam int NANO_W = 56;
    localparam int NANO_DEPTH = 512;
    localparam int NANO_AW = 9;
    localparam int LIT_W = 8;
    localparam int SAR_W = 4;
    localparam int SEL_W = 3;

    // microinstruction field positions (word bit n sits at index n-1)
    localparam int MI_TYPE_BIT = 0;
    localparam int MI_DEST_BIT = 1;
    localparam int MI_SEL_LO = 2;
    localparam int MI_SEL_W = 2;
    localparam int MI_SAR_LO = 4;
    localparam int MI_NANO_LO = 7;
    localparam int MI_LIT_LO = 8;
    localparam int MI_ALT_LO = 2;
    localparam int MI_PAR_BIT = 16;

    // nanoword field positions
    localparam int NANO_SEL_LO = 0;

    // reset values
    localparam logic [ADDR_W-1:0] RST_ADDR = 14'h0000;
    localparam logic [NANO_W-1:0] RST_NANO = 56'h0;
    localparam logic [LIT_W-1:0] RST_LIT = 8'h00;
    localparam logic [SAR_W-1:0] RST_SAR = 4'h0;

    // increments
    localparam logic [ADDR_W-1:0] STEP_ONE = 14'h0001;
    localparam logic [ADDR_W-1:0] STEP_TWO = 14'h0002;

    // next-address source selection
    typedef enum logic [SEL_W-1:0] {
        MSEQ_SEL_CNT1 = 3'h0,
        MSEQ_SEL_CNT2 = 3'h1,
        MSEQ_SEL_ALT1 = 3'h2,
        MSEQ_SEL_ALT2 = 3'h3,
        MSEQ_SEL_MEM1 = 3'h4
    } mseq_sel_t;
endpackage : mseq_pkg

// ### logic/mseq_sel_if.sv
// selection bundle between sequencer control and next-address arithmetic
`timescale 1ns/1ns
`default_nettype none
interface mseq_sel_if;
    mseq_pkg::mseq_sel_t sel;
    logic [mseq_pkg::ADDR_W-1:0] count;
    logic [mseq_pkg::ADDR_W-1:0] alt;
    logic [mseq_pkg::ADDR_W-1:0] word;
    logic [mseq_pkg::ADDR_W-1:0] next;
    modport user (output sel, output count, output alt, output word, input next);
    modport calc (input sel, input count, input alt, input word, output next);
endinterface : mseq_sel_if
`default_nettype wire

// ### logic/mseq_next_addr.sv
// next-address arithmetic: five increment choices
`timescale 1ns/1ns
`default_nettype none
module mseq_next_addr (
    mseq_sel_if.calc sif
);
    // address plus a small step, wrapping at the address width
    function automatic logic [mseq_pkg::ADDR_W-1:0] addr_add(
        input logic [mseq_pkg::ADDR_W-1:0] base,
        input logic [mseq_pkg::ADDR_W-1:0] step
    );
        addr_add = base + step;
    endfunction : addr_add

    // pick the source and step
    always_comb begin
        case (sif.sel)
            mseq_pkg::MSEQ_SEL_CNT1: sif.next = addr_add(sif.count, mseq_pkg::STEP_ONE);
            mseq_pkg::MSEQ_SEL_CNT2: sif.next = addr_add(sif.count, mseq_pkg::STEP_TWO);
            mseq_pkg::MSEQ_SEL_ALT1: sif.next = addr_add(sif.alt, mseq_pkg::STEP_ONE);
            mseq_pkg::MSEQ_SEL_ALT2: sif.next = addr_add(sif.alt, mseq_pkg::STEP_TWO);
            mseq_pkg::MSEQ_SEL_MEM1: sif.next = addr_add(sif.word, mseq_pkg::STEP_ONE);
            default: sif.next = addr_add(sif.count, mseq_pkg::STEP_ONE);
        endcase
    end
endmodule : mseq_next_addr
`default_nettype wire

// ### logic/mseq_sequencer.sv
// microprogram sequencer: address registers, fetch/execute phasing, nanobit control register
`timescale 1ns/1ns
`default_nettype none
module mseq_sequencer (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    // micro store
    output logic [mseq_pkg::ADDR_W-1:0] MICRO_ADDR_OUT,
    input wire logic [mseq_pkg::MI_W-1:0] MICRO_DATA_IN,
    // nano store
    output logic [mseq_pkg::NANO_AW-1:0] NANO_ADDR_OUT,
    input wire logic [mseq_pkg::NANO_W-1:0] NANO_DATA_IN,
    // datapath control
    output logic [mseq_pkg::NANO_W-1:0] NANOBITS_OUT,
    output logic EXEC_OUT,
    output logic [mseq_pkg::LIT_W-1:0] LITERAL_OUT,
    output logic [mseq_pkg::SAR_W-1:0] SHIFT_AMT_OUT,
    // checking
    output logic PARITY_ERR_OUT
);
    logic rst_meta_r;
    logic rst_sync_r;
    logic rst_n;
    logic [mseq_pkg::ADDR_W-1:0] next_address_reg_r;
    logic [mseq_pkg::ADDR_W-1:0] micro_count_reg_r;
    logic [mseq_pkg::ADDR_W-1:0] alternate_count_reg_r;
    logic [mseq_pkg::NANO_W-1:0] ctrl_r;
    logic exec_r;
    logic [mseq_pkg::LIT_W-1:0] lit_r;
    logic [mseq_pkg::SAR_W-1:0] sar_r;
    logic par_err_r;
    logic is_type2;
    logic dest_alt;
    logic load_alt;
    logic load_lit;
    logic [mseq_pkg::ADDR_W-1:0] word_field;
    logic [mseq_pkg::ADDR_W-1:0] next_address_nxt;
    logic [mseq_pkg::SEL_W-1:0] nano_sel_code;
    logic [mseq_pkg::MI_SEL_W-1:0] mi_sel_code;
    logic par_bad;
    mseq_pkg::mseq_sel_t sel;
    mseq_sel_if sif ();

    // reset release through two flops
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rst_n = rst_sync_r;

    // micro word field decode
    assign is_type2 = MICRO_DATA_IN[mseq_pkg::MI_TYPE_BIT];
    assign dest_alt = MICRO_DATA_IN[mseq_pkg::MI_DEST_BIT];
    assign mi_sel_code = MICRO_DATA_IN[mseq_pkg::MI_SEL_LO +: mseq_pkg::MI_SEL_W];
    assign word_field = MICRO_DATA_IN[mseq_pkg::MI_ALT_LO +: mseq_pkg::ADDR_W];
    assign load_alt = is_type2 && dest_alt;
    assign load_lit = is_type2 && !dest_alt;
    assign nano_sel_code = ctrl_r[mseq_pkg::NANO_SEL_LO +: mseq_pkg::SEL_W];

    // nano address straight from the type I word
    assign NANO_ADDR_OUT = MICRO_DATA_IN[mseq_pkg::MI_NANO_LO +: mseq_pkg::NANO_AW];

    // next-address source selection
    always_comb begin
        sel = mseq_pkg::MSEQ_SEL_CNT1;
        if (is_type2) begin
            if (!dest_alt) begin
                sel = mseq_pkg::mseq_sel_t'({1'b0, mi_sel_code});
            end
        end else if (exec_r) begin
            if (nano_sel_code <= mseq_pkg::MSEQ_SEL_MEM1) begin
                sel = mseq_pkg::mseq_sel_t'(nano_sel_code);
            end
        end
    end

    // next-address arithmetic
    assign sif.sel = sel;
    assign sif.count = micro_count_reg_r;
    assign sif.alt = alternate_count_reg_r;
    assign sif.word = word_field;
    assign next_address_nxt = sif.next;
    mseq_next_addr mseq_next_addr_inst (
        .sif (sif.calc)
    );

    // next-address register drives the fetch address
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            next_address_reg_r <= mseq_pkg::RST_ADDR;
        end else begin
            next_address_reg_r <= next_address_nxt;
        end
    end
    assign MICRO_ADDR_OUT = next_address_reg_r;

    // present count follows the flow, held over alternate jumps
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            micro_count_reg_r <= mseq_pkg::RST_ADDR;
        end else if (sel != mseq_pkg::MSEQ_SEL_ALT1 && sel != mseq_pkg::MSEQ_SEL_ALT2) begin
            micro_count_reg_r <= next_address_nxt;
        end
    end

    // alternate count preset by type II
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            alternate_count_reg_r <= mseq_pkg::RST_ADDR;
        end else if (load_alt) begin
            alternate_count_reg_r <= word_field;
        end
    end

    // literal and shift-amount presets complete in the fetch cycle
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            lit_r <= mseq_pkg::RST_LIT;
            sar_r <= mseq_pkg::RST_SAR;
        end else if (load_lit) begin
            lit_r <= MICRO_DATA_IN[mseq_pkg::MI_LIT_LO +: mseq_pkg::LIT_W];
            sar_r <= MICRO_DATA_IN[mseq_pkg::MI_SAR_LO +: mseq_pkg::SAR_W];
        end
    end
    assign LITERAL_OUT = lit_r;
    assign SHIFT_AMT_OUT = sar_r;

    // fetch latches nanobits, the next cycle executes them
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= mseq_pkg::RST_NANO;
            exec_r <= 1'b0;
        end else if (!is_type2) begin
            ctrl_r <= NANO_DATA_IN;
            exec_r <= 1'b1;
        end else begin
            ctrl_r <= mseq_pkg::RST_NANO;
            exec_r <= 1'b0;
        end
    end
    assign NANOBITS_OUT = ctrl_r;
    assign EXEC_OUT = exec_r;

    // odd parity over all 17 bits of each fetched word
    assign par_bad = ~(^MICRO_DATA_IN);
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            par_err_r <= 1'b0;
        end else begin
            par_err_r <= par_bad;
        end
    end
    assign PARITY_ERR_OUT = par_err_r;

    // checks
    AST_NANO_ADDR: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        !is_type2 |-> NANO_ADDR_OUT == MICRO_DATA_IN[15:7])
        else $error("nano address not taken from word bits 8 to 16");

    AST_COUNT_HOLD: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (sel == mseq_pkg::MSEQ_SEL_ALT1 || sel == mseq_pkg::MSEQ_SEL_ALT2)
        |=> $stable(micro_count_reg_r))
        else $error("count changed on an alternate jump");

    AST_ALT_LOAD: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        load_alt |=> alternate_count_reg_r == $past(word_field) ##1
        ($past(load_alt) || $stable(alternate_count_reg_r)))
        else $error("alternate count not loaded or not held");

    AST_NEXT_CNT2: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        sel == mseq_pkg::MSEQ_SEL_CNT2 |=>
        MICRO_ADDR_OUT == $past(micro_count_reg_r) + mseq_pkg::STEP_TWO)
        else $error("count plus two not driven to micro address");

    AST_NEXT_MEM: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        sel == mseq_pkg::MSEQ_SEL_MEM1 |=>
        MICRO_ADDR_OUT == $past(word_field) + mseq_pkg::STEP_ONE)
        else $error("word plus one not driven to micro address");

    AST_SEL_TYPE2: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (load_lit && mi_sel_code == 2'h2) |=>
        MICRO_ADDR_OUT == $past(alternate_count_reg_r) + mseq_pkg::STEP_ONE)
        else $error("type II select of alternate plus one ignored");

    AST_EXEC_LATER: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        !is_type2 |=> EXEC_OUT && NANOBITS_OUT == $past(NANO_DATA_IN))
        else $error("type I nanobits not applied in the following cycle");

    AST_TYPE2_NO_EXEC: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        is_type2 |=> !EXEC_OUT && NANOBITS_OUT == mseq_pkg::RST_NANO)
        else $error("execute cycle after a type II word");

    AST_LIT_LOAD: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        load_lit |=> LITERAL_OUT == $past(MICRO_DATA_IN[15:8])
        && SHIFT_AMT_OUT == $past(MICRO_DATA_IN[7:4]))
        else $error("literal or shift preset missed in fetch cycle");

    AST_PARITY: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        ##1 PARITY_ERR_OUT == $past(par_bad))
        else $error("parity flag does not match fetched word");

    AST_RESET_START: assert property (@(posedge CLK_IN)
        $rose(rst_n) |-> MICRO_ADDR_OUT == mseq_pkg::RST_ADDR && !EXEC_OUT
        && NANOBITS_OUT == mseq_pkg::RST_NANO)
        else $error("sequencer not at zero with clear control after reset");

    // select paths, register holds and phasing seen from the outputs and the count registers
    AST_NEXT_CNT1: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        sel == mseq_pkg::MSEQ_SEL_CNT1 |=>
        MICRO_ADDR_OUT == $past(micro_count_reg_r) + mseq_pkg::STEP_ONE)
        else $error("count plus one not driven to micro address");

    AST_NEXT_ALT1: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        sel == mseq_pkg::MSEQ_SEL_ALT1 |=>
        MICRO_ADDR_OUT == $past(alternate_count_reg_r) + mseq_pkg::STEP_ONE)
        else $error("alternate plus one not driven to micro address");

    AST_NEXT_ALT2: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        sel == mseq_pkg::MSEQ_SEL_ALT2 |=>
        MICRO_ADDR_OUT == $past(alternate_count_reg_r) + mseq_pkg::STEP_TWO)
        else $error("alternate plus two not driven to micro address");

    AST_COUNT_FOLLOW: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        !(sel == mseq_pkg::MSEQ_SEL_ALT1 || sel == mseq_pkg::MSEQ_SEL_ALT2) |=>
        micro_count_reg_r == MICRO_ADDR_OUT)
        else $error("count did not follow the new address");

    AST_ALT_HOLD: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        !load_alt |=>
        $stable(alternate_count_reg_r))
        else $error("alternate count changed without a preset");

    AST_NANO_REFUSED: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (!is_type2 && EXEC_OUT && NANOBITS_OUT[2:0] > 3'h4) |=>
        MICRO_ADDR_OUT == $past(micro_count_reg_r) + mseq_pkg::STEP_ONE)
        else $error("unused nano select code did not step the count");

    AST_NANO_ALT2: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (!is_type2 && EXEC_OUT && NANOBITS_OUT[2:0] == 3'h3) |=>
        MICRO_ADDR_OUT == $past(alternate_count_reg_r) + mseq_pkg::STEP_TWO)
        else $error("nano select of alternate plus two ignored");

    AST_CTRL_IDLE: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        !EXEC_OUT |-> NANOBITS_OUT == mseq_pkg::RST_NANO)
        else $error("control register not clear outside an execute cycle");

    AST_FIRST_SEL: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (!is_type2 && !EXEC_OUT) |=>
        MICRO_ADDR_OUT == $past(micro_count_reg_r) + mseq_pkg::STEP_ONE)
        else $error("type I word steered the address in its own fetch cycle");

    AST_EXEC_SOURCE: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        EXEC_OUT |-> $past(is_type2) == 1'b0)
        else $error("execute cycle not preceded by a type I fetch");

    AST_LIT_HOLD: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        !load_lit |=> $stable(LITERAL_OUT) && $stable(SHIFT_AMT_OUT))
        else $error("literal or shift amount changed without a preset");

    AST_TYPE2_CNT2: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        MICRO_DATA_IN[3:0] == 4'h5 |=>
        MICRO_ADDR_OUT == $past(micro_count_reg_r) + mseq_pkg::STEP_TWO)
        else $error("type II select of count plus two ignored");

    AST_DEST_ALT: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        MICRO_DATA_IN[1:0] == 2'h3 |=>
        MICRO_ADDR_OUT == $past(micro_count_reg_r) + mseq_pkg::STEP_ONE)
        else $error("alternate preset did not step the count");

    AST_PARITY_ODD: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        ##1 PARITY_ERR_OUT == !$past(^MICRO_DATA_IN))
        else $error("parity flag disagrees with odd parity of the word");

    AST_RESET_REGS: assert property (@(posedge CLK_IN)
        $rose(rst_n) |-> micro_count_reg_r == mseq_pkg::RST_ADDR
        && alternate_count_reg_r == mseq_pkg::RST_ADDR && !PARITY_ERR_OUT)
        else $error("count registers or parity flag not clear after reset");
endmodule : mseq_sequencer
`default_nettype wire

// ### dv/mseq_store_model.sv
// behavioural micro store and nano store facing the sequencer
`timescale 1ns/1ns
`default_nettype none
module mseq_store_model (
    // micro store side
    input wire logic [mseq_pkg::ADDR_W-1:0] micro_addr_in,
    output logic [mseq_pkg::MI_W-1:0] micro_data_out,
    // nano store side
    input wire logic [mseq_pkg::NANO_AW-1:0] nano_addr_in,
    output logic [mseq_pkg::NANO_W-1:0] nano_data_out
);
    // contents are filled by the bench before reset is released
    logic [mseq_pkg::MI_W-1:0] micro_mem [0:(1<<mseq_pkg::ADDR_W)-1];
    logic [mseq_pkg::NANO_W-1:0] nano_mem [0:mseq_pkg::NANO_DEPTH-1];
    // both stores answer within the same cycle, never stalling
    assign micro_data_out = micro_mem[micro_addr_in];
    assign nano_data_out = nano_mem[nano_addr_in];
endmodule : mseq_store_model
`default_nettype wire

// ### dv/microprogram_sequencer_bench.sv
// self-checking bench for the microprogram sequencer
`timescale 1ns/1ns
`default_nettype none
module microprogram_sequencer_bench;
    localparam logic [55:0] NANO_HI = 56'hc3_0000_0000_0004; // selects word plus one
    localparam logic [55:0] NANO_LO = 56'h00_0000_0000_a5a0; // selects count plus one
    localparam logic [55:0] NANO_C2 = 56'h5a_0000_0000_0001; // selects count plus two
    localparam logic [55:0] NANO_A2 = 56'h81_0000_0000_0003; // selects alternate plus two
    localparam logic [55:0] NANO_BAD = 56'h00_ff00_0000_0007; // unused code, steps the count
    logic clk;
    logic arst_n;
    logic [mseq_pkg::ADDR_W-1:0] maddr;
    logic [mseq_pkg::MI_W-1:0] mdata;
    logic [mseq_pkg::NANO_AW-1:0] naddr;
    logic [mseq_pkg::NANO_W-1:0] ndata;
    logic [mseq_pkg::NANO_W-1:0] nbits;
    logic exec;
    logic [mseq_pkg::LIT_W-1:0] lit;
    logic [mseq_pkg::SAR_W-1:0] sar;
    logic perr;
    int error_cnt;
    int check_count;

    // design and its stores
    mseq_sequencer mseq_sequencer_inst (
        .CLK_IN(clk), .ARST_N_IN(arst_n), .MICRO_ADDR_OUT(maddr), .MICRO_DATA_IN(mdata),
        .NANO_ADDR_OUT(naddr), .NANO_DATA_IN(ndata), .NANOBITS_OUT(nbits), .EXEC_OUT(exec),
        .LITERAL_OUT(lit), .SHIFT_AMT_OUT(sar), .PARITY_ERR_OUT(perr)
    );
    mseq_store_model mseq_store_model_inst (
        .micro_addr_in(maddr), .micro_data_out(mdata),
        .nano_addr_in(naddr), .nano_data_out(ndata)
    );

    // 125 MHz clock
    initial clk = 1'b0;
    always #4 clk = ~clk;

    // word with odd parity over all 17 bits
    function automatic logic [16:0] mw(input logic [15:0] b);
        return {~^b, b};
    endfunction : mw

    task automatic chk(input string what, input logic [55:0] exp, input logic [55:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one clock, then sample where outputs have settled
    task automatic step();
        @(posedge clk);
        @(negedge clk);
    endtask : step

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic test_reset(input int n);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (n) @(posedge clk);
        @(negedge clk);
        chk("reset address", '0, maddr);
        chk("reset control", '0, nbits);
        chk("reset execute", '0, exec);
        @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("held address", '0, maddr);
        $display("reset test done");
    endtask : test_reset

    task automatic test_type2();
        step();
        chk("address", 14'h0002, maddr);
        chk("literal", 8'h5a, lit);
        chk("shift", 4'h3, sar);
        chk("execute", '0, exec);
        step();
        chk("address", 14'h0003, maddr);
        step();
        chk("address", 14'h0101, maddr);
        chk("literal", 8'h00, lit);
        step();
        chk("address", 14'h0102, maddr);
        step();
        chk("address", 14'h0004, maddr);
        $display("type two test done");
    endtask : test_type2

    task automatic test_type1();
        chk("nano address", 9'h1ff, naddr);
        chk("execute", '0, exec);
        step();
        chk("address", 14'h0005, maddr);
        chk("execute", 1'b1, exec);
        chk("control", NANO_HI, nbits);
        chk("nano address", 9'h002, naddr);
        step();
        chk("address", 14'h0041, maddr);
        chk("control", NANO_LO, nbits);
        step();
        chk("address", 14'h0042, maddr);
        chk("execute", '0, exec);
        chk("control", '0, nbits);
        $display("type one test done");
    endtask : test_type1

    task automatic test_parity();
        chk("parity", '0, perr);
        step();
        chk("address", 14'h0043, maddr);
        chk("parity", 1'b1, perr);
        step();
        chk("parity", '0, perr);
        $display("parity test done");
    endtask : test_parity

    // chain of type I words steering by the latched select codes
    task automatic test_nano_sel();
        chk("nano address", 9'h003, naddr);
        step();
        chk("address", 14'h0045, maddr);
        chk("control", NANO_C2, nbits);
        step();
        chk("address", 14'h0047, maddr);
        chk("control", NANO_BAD, nbits);
        step();
        chk("address", 14'h0048, maddr);
        chk("control", NANO_A2, nbits);
        step();
        chk("address", 14'h0102, maddr);
        chk("execute", 1'b1, exec);
        step();
        chk("address", 14'h0049, maddr);
        chk("execute", '0, exec);
        $display("nano select test done");
    endtask : test_nano_sel

    // store contents, then the scenarios, a mid-run reset and a rerun
    initial begin
        arst_n <= 1'b0;
        error_cnt = 0;
        check_count = 0;
        for (int i = 0; i < 16384; i++) begin
            mseq_store_model_inst.micro_mem[i] = mw(16'h0001);
        end
        for (int i = 0; i < 512; i++) begin
            mseq_store_model_inst.nano_mem[i] = '0;
        end
        mseq_store_model_inst.nano_mem[9'h1ff] = NANO_HI;
        mseq_store_model_inst.nano_mem[9'h002] = NANO_LO;
        mseq_store_model_inst.micro_mem[14'h0000] = mw(16'h5a35);
        mseq_store_model_inst.micro_mem[14'h0002] = mw(16'h0403);
        mseq_store_model_inst.micro_mem[14'h0003] = mw(16'h0009);
        mseq_store_model_inst.micro_mem[14'h0101] = mw(16'h000d);
        mseq_store_model_inst.micro_mem[14'h0004] = mw(16'hff80);
        mseq_store_model_inst.micro_mem[14'h0005] = mw(16'h0100);
        mseq_store_model_inst.micro_mem[14'h0042] = {1'b1, 16'h0001};
        mseq_store_model_inst.nano_mem[9'h003] = NANO_C2;
        mseq_store_model_inst.nano_mem[9'h004] = NANO_A2;
        mseq_store_model_inst.nano_mem[9'h006] = NANO_BAD;
        mseq_store_model_inst.micro_mem[14'h0044] = mw(16'h0180);
        mseq_store_model_inst.micro_mem[14'h0045] = mw(16'h0300);
        mseq_store_model_inst.micro_mem[14'h0047] = mw(16'h0200);
        mseq_store_model_inst.micro_mem[14'h0048] = mw(16'h0180);
        test_reset(10);
        test_type2();
        test_type1();
        test_parity();
        test_nano_sel();
        test_reset(2);
        test_type2();
        end_sim();
    end

    // cut a hung run short
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        $display("unexpected timeout: expected end seen none");
        end_sim();
    end
endmodule : microprogram_sequencer_bench
`default_nettype wire
